// ---- logic/rx_afc_pkg.sv ----
// constants, carriers and state layout of the receiver correction, slicer and strength register bank
// assumes an axi4-lite master with 32-bit data and 8-bit byte addresses; register index = byte address / 4
// Behaviour
// [RQ1] during a correction phase the correction filter fields replace normal bandwidth settings
// [RQ2] threshold type 00 fixed, 01 peak, 10 average, 11 reserved
// [RQ3] peak decay step codes 0..7 give 0.5,1,1.5,2,3,4,5,6 dB
// [RQ4] decay rate codes 0..3 once per 1,2,4,8 chips; 4..7 give 2,4,8,16 per chip
// [RQ5] average corner codes 0..3 give chip rate over 32pi, 8pi, 4pi, 2pi
// [RQ6] fixed type uses the 8-bit fixed level in dB, reset 6 dB
// [RQ7] error trigger starts a measurement, reads zero; error done low while measuring
// [RQ8] frequency error is a 16-bit two's complement value in high and low registers
// [RQ9] correction trigger starts correction, reads zero; correction done low while running, resets one
// [RQ10] auto enable runs correction on every receive entry, else only on trigger
// [RQ11] with auto enabled and auto-zero set, correction value zeroes before each phase
// [RQ12] writing correction-zero while in receive mode zeroes the correction value; reads zero
// [RQ13] applied correction is 16-bit two's complement in two read-only registers, reset zero
// [RQ14] strength trigger starts a strength measurement and always reads zero
// [RQ15] strength done low while sampling, high with result available, resets to one
// [RQ16] strength result holds level in half-dB steps, resets to all ones
// [RQ17] each done flag drops the cycle after its trigger, rises on result update
// [RQ18] unused bits ignore writes and read as zero
package rx_afc_pkg;

  localparam logic [5:0] IDX_CORR_BW = 6'h1a;
  localparam logic [5:0] IDX_PEAK_CFG = 6'h1b;
  localparam logic [5:0] IDX_AVG_CFG = 6'h1c;
  localparam logic [5:0] IDX_FIXED = 6'h1d;
  localparam logic [5:0] IDX_CORR_CTRL = 6'h1e;
  localparam logic [5:0] IDX_CORR_HI = 6'h1f;
  localparam logic [5:0] IDX_CORR_LO = 6'h20;
  localparam logic [5:0] IDX_ERR_HI = 6'h21;
  localparam logic [5:0] IDX_ERR_LO = 6'h22;
  localparam logic [5:0] IDX_STR_CTRL = 6'h23;
  localparam logic [5:0] IDX_STR_RESULT = 6'h24;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

  // field positions in the control registers
  localparam int BIT_ERR_DONE = 6;
  localparam int BIT_ERR_TRIG = 5;
  localparam int BIT_CORR_DONE = 4;
  localparam int BIT_AUTO_ZERO = 3;
  localparam int BIT_AUTO_ON = 2;
  localparam int BIT_CORR_ZERO = 1;
  localparam int BIT_CORR_TRIG = 0;
  localparam int BIT_STR_DONE = 1;
  localparam int BIT_STR_TRIG = 0;

  // interrupt status bit positions
  localparam int IRQ_CORR = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_STR = 2;

  localparam logic [7:0] RST_CORR_BW = 8'h8b;
  localparam logic [7:0] RST_PEAK_CFG = 8'h40;
  localparam logic [1:0] RST_AVG_CORNER = 2'h2;
  localparam logic [7:0] RST_FIXED = 8'h06;
  localparam logic [7:0] RST_STR_LEVEL = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] TYPE_FIXED = 2'h0;
  localparam logic [1:0] TYPE_PEAK = 2'h1;
  localparam logic [1:0] TYPE_AVERAGE = 2'h2;

  typedef struct packed {
    logic [2:0] dc_cutoff;
    logic [1:0] mantissa;
    logic [2:0] exponent;
  } filter_cfg_s;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } result_s;

  typedef struct packed {
    logic [1:0] threshold_type;
    logic [3:0] step_half_db;
    logic [1:0] decay_chips_log2;
    logic [2:0] decays_per_chip_log2;
    logic [5:0] corner_div_pi;
    logic [7:0] fixed_level;
  } slicer_cfg_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] aw_idx;
    logic [7:0] wdata;
    logic wlane;
    logic [7:0] corr_bw;
    logic [7:0] peak_cfg;
    logic [1:0] avg_corner;
    logic [7:0] fixed_level;
    logic auto_zero;
    logic auto_on;
    logic err_done;
    logic corr_done;
    logic str_done;
    logic [15:0] corr_value;
    logic [15:0] err_value;
    logic [7:0] str_level;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic irq;
    logic rx_prev;
    logic err_start;
    logic corr_start;
    logic corr_clear;
    logic str_start;
    filter_cfg_s active_filter;
    slicer_cfg_s slicer;
  } state_s;

endpackage

// ---- logic/rx_afc_ook_rssi_regs.sv ----
// register bank for correction filter settings, slicer setup and the three measurement engines
// assumes the measurement datapath takes one-cycle start pulses and returns one-cycle result strobes
`timescale 1ns/100ps

module rx_afc_ook_rssi_regs
  import rx_afc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic rx_mode,
  input wire filter_cfg_s normal_filter,
  input wire result_s error_result,
  input wire result_s correction_result,
  input wire result_s strength_result,
  output filter_cfg_s active_filter,
  output slicer_cfg_s slicer_cfg,
  output logic error_measure_start,
  output logic correction_start,
  output logic correction_clear,
  output logic strength_start,
  output logic irq
);

  state_s s_q;
  state_s s_d;

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= IDX_CORR_BW && idx <= IDX_STR_RESULT) ||
      idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
  endfunction

  function automatic logic [7:0] read_reg(input state_s s, input logic [5:0] idx);
    read_reg = 8'h00;
    case (idx)
      IDX_CORR_BW: read_reg = s.corr_bw;
      IDX_PEAK_CFG: read_reg = s.peak_cfg;
      IDX_AVG_CFG: read_reg = {s.avg_corner, 6'h00}; // [RQ18]
      IDX_FIXED: read_reg = s.fixed_level;
      // trigger and zero bits are never stored, so they read zero
      IDX_CORR_CTRL: read_reg = {1'b0, s.err_done, 1'b0, s.corr_done, s.auto_zero, s.auto_on, 2'h0}; // [RQ7] [RQ9]
      IDX_CORR_HI: read_reg = s.corr_value[15:8]; // [RQ13]
      IDX_CORR_LO: read_reg = s.corr_value[7:0];
      IDX_ERR_HI: read_reg = s.err_value[15:8]; // [RQ8]
      IDX_ERR_LO: read_reg = s.err_value[7:0];
      IDX_STR_CTRL: read_reg = {6'h00, s.str_done, 1'b0}; // [RQ14] [RQ15]
      IDX_STR_RESULT: read_reg = s.str_level; // [RQ16]
      IDX_IRQ_STATUS: read_reg = {5'h00, s.irq_status};
      IDX_IRQ_MASK: read_reg = {5'h00, s.irq_mask};
      default: read_reg = 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] step_decode(input logic [2:0] code);
    case (code)
      3'h0: step_decode = 4'h1;
      3'h1: step_decode = 4'h2;
      3'h2: step_decode = 4'h3;
      3'h3: step_decode = 4'h4;
      3'h4: step_decode = 4'h6;
      3'h5: step_decode = 4'h8;
      3'h6: step_decode = 4'ha;
      default: step_decode = 4'hc;
    endcase
  endfunction

  function automatic logic [5:0] corner_decode(input logic [1:0] code);
    case (code)
      2'h0: corner_decode = 6'h20;
      2'h1: corner_decode = 6'h08;
      2'h2: corner_decode = 6'h04;
      default: corner_decode = 6'h02;
    endcase
  endfunction

  logic do_write;
  logic wr_hit;
  logic [7:0] wv;
  logic rx_entry;
  logic corr_go;
  logic [2:0] irq_events;
  logic [2:0] irq_w1c;

  always_comb
  begin
    s_d = s_q;
    do_write = !s_q.awready && !s_q.wready && !s_q.bvalid;
    wr_hit = do_write && s_q.wlane && is_mapped(s_q.aw_idx);
    wv = s_q.wdata;
    rx_entry = rx_mode && !s_q.rx_prev;
    irq_events = 3'h0;
    irq_w1c = 3'h0;
    corr_go = 1'b0;
    s_d.rx_prev = rx_mode;
    s_d.err_start = 1'b0;
    s_d.corr_start = 1'b0;
    s_d.corr_clear = 1'b0;
    s_d.str_start = 1'b0;

    // address and data are taken independently; the write happens once both are held
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.awready = 1'b0;
      s_d.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.wready = 1'b0;
      s_d.wdata = s_axi_wdata[7:0];
      s_d.wlane = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // results land first so that a trigger in the same cycle still restarts the measurement
    if (error_result.valid && !s_q.err_done)
    begin
      s_d.err_value = error_result.value; // [RQ8]
      s_d.err_done = 1'b1; // [RQ17]
      irq_events[IRQ_ERR] = 1'b1;
    end
    if (correction_result.valid && !s_q.corr_done)
    begin
      s_d.corr_value = correction_result.value; // [RQ13]
      s_d.corr_done = 1'b1; // [RQ17]
      irq_events[IRQ_CORR] = 1'b1;
    end
    if (strength_result.valid && !s_q.str_done)
    begin
      s_d.str_level = strength_result.value[7:0]; // [RQ16]
      s_d.str_done = 1'b1; // [RQ15] [RQ17]
      irq_events[IRQ_STR] = 1'b1;
    end

    if (wr_hit)
    begin
      case (s_q.aw_idx)
        IDX_CORR_BW: s_d.corr_bw = wv;
        IDX_PEAK_CFG: s_d.peak_cfg = wv;
        IDX_AVG_CFG: s_d.avg_corner = wv[7:6]; // [RQ18]
        IDX_FIXED: s_d.fixed_level = wv;
        IDX_CORR_CTRL:
        begin
          s_d.auto_zero = wv[BIT_AUTO_ZERO];
          s_d.auto_on = wv[BIT_AUTO_ON];
          if (wv[BIT_ERR_TRIG])
          begin
            s_d.err_done = 1'b0; // [RQ7] [RQ17]
            s_d.err_start = 1'b1;
          end
          if (wv[BIT_CORR_TRIG])
            corr_go = 1'b1; // [RQ9]
          if (wv[BIT_CORR_ZERO] && rx_mode)
          begin
            s_d.corr_value = 16'h0000; // [RQ12]
            s_d.corr_clear = 1'b1;
          end
        end
        IDX_STR_CTRL:
        begin
          if (wv[BIT_STR_TRIG])
          begin
            s_d.str_done = 1'b0; // [RQ14] [RQ17]
            s_d.str_start = 1'b1;
          end
        end
        IDX_IRQ_STATUS: irq_w1c = wv[2:0];
        IDX_IRQ_MASK: s_d.irq_mask = wv[2:0];
        default: s_d.irq_mask = s_q.irq_mask;
      endcase
    end

    // receive entry only starts a phase when automatic mode was already on
    if (rx_entry && s_q.auto_on)
      corr_go = 1'b1; // [RQ10]
    if (corr_go)
    begin
      s_d.corr_done = 1'b0; // [RQ9] [RQ17]
      s_d.corr_start = 1'b1;
      if (s_q.auto_on && s_q.auto_zero)
        s_d.corr_value = 16'h0000; // [RQ11]
    end

    // a new event wins over a clear written in the same cycle
    s_d.irq_status = (s_q.irq_status & ~irq_w1c) | irq_events;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);

    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h000000, read_reg(s_q, s_axi_araddr[7:2])};
      s_d.rresp = is_mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // filter follows the next state so the switch lines up with the done flag
    if (!s_d.corr_done)
      s_d.active_filter = filter_cfg_s'(s_d.corr_bw); // [RQ1]
    else
      s_d.active_filter = normal_filter;

    s_d.slicer.threshold_type = s_d.peak_cfg[7:6]; // [RQ2]
    s_d.slicer.step_half_db = step_decode(s_d.peak_cfg[5:3]); // [RQ3]
    s_d.slicer.decay_chips_log2 = s_d.peak_cfg[2] ? 2'h0 : s_d.peak_cfg[1:0]; // [RQ4]
    s_d.slicer.decays_per_chip_log2 = s_d.peak_cfg[2] ? {1'b0, s_d.peak_cfg[1:0]} + 3'h1 : 3'h0; // [RQ4]
    s_d.slicer.corner_div_pi = corner_decode(s_d.avg_corner); // [RQ5]
    // level is only meaningful to the slicer in fixed mode; elsewhere it reads as zero
    s_d.slicer.fixed_level = (s_d.peak_cfg[7:6] == TYPE_FIXED) ? s_d.fixed_level : 8'h00; // [RQ6]
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.corr_bw <= RST_CORR_BW;
      s_q.peak_cfg <= RST_PEAK_CFG;
      s_q.avg_corner <= RST_AVG_CORNER;
      s_q.fixed_level <= RST_FIXED; // [RQ6]
      s_q.corr_done <= 1'b1; // [RQ9]
      s_q.str_done <= 1'b1; // [RQ15]
      s_q.str_level <= RST_STR_LEVEL; // [RQ16]
      s_q.active_filter <= filter_cfg_s'(8'h00);
      s_q.slicer.threshold_type <= RST_PEAK_CFG[7:6];
      s_q.slicer.step_half_db <= 4'h1;
      s_q.slicer.corner_div_pi <= 6'h04;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign active_filter = s_q.active_filter;
  assign slicer_cfg = s_q.slicer;
  assign error_measure_start = s_q.err_start;
  assign correction_start = s_q.corr_start;
  assign correction_clear = s_q.corr_clear;
  assign strength_start = s_q.str_start;
  assign irq = s_q.irq;

endmodule

// ---- tb/rx_afc_chk.sv ----
// concurrent checks on the bank's bus, slicer and pulse outputs
// assumes binding to the bank top; clk_en low pauses every check
`timescale 1ns/100ps
module rx_afc_chk
  import rx_afc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_mode,
  input wire slicer_cfg_s slicer_cfg,
  input wire logic error_measure_start,
  input wire logic correction_clear
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || !clk_en);
  property p_wresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_err_pulse;
    error_measure_start |=> !error_measure_start;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error start too long");
  property p_fixed;
    slicer_cfg.threshold_type != TYPE_FIXED |-> slicer_cfg.fixed_level == 8'h0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed level leaks");
  property p_step;
    slicer_cfg.step_half_db inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
  endproperty
  a_step: assert property (p_step) else $error("bad decay step");
  property p_corner;
    slicer_cfg.corner_div_pi inside {6'h20, 6'h8, 6'h4, 6'h2};
  endproperty
  a_corner: assert property (p_corner) else $error("bad corner");
  property p_decay;
    slicer_cfg.decay_chips_log2 == 2'h0 || slicer_cfg.decays_per_chip_log2 == 3'h0;
  endproperty
  a_decay: assert property (p_decay) else $error("both decay fields set");
  property p_clear;
    correction_clear |-> $past(rx_mode) || $past(rx_mode, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("clear outside receive");
endmodule
bind rx_afc_ook_rssi_regs rx_afc_chk rx_afc_chk_i (.clk_sys, .reset, .clk_en, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .rx_mode, .slicer_cfg, .error_measure_start, .correction_clear);

// ---- tb/rx_afc_ook_rssi_regs_test.sv ----
// self-checking bench for the correction, slicer and strength register bank
// assumes package and checker compiled first; clk_en held high
`timescale 1ns/100ps
module rx_afc_ook_rssi_regs_test;
  import rx_afc_pkg::*;
  logic clk_sys = 0, reset = 1, clk_en = 1, rx_mode = 0, irq;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  filter_cfg_s normal_filter = 8'h55, active_filter;
  result_s error_result = '0, correction_result = '0, strength_result = '0;
  slicer_cfg_s slicer_cfg;
  logic error_measure_start, correction_start, correction_clear, strength_start;
  int fails = 0, n_tests = 0, cyc = 0, n_corr = 0, n_err = 0, n_str = 0, n_clr = 0;
  rx_afc_ook_rssi_regs rx_afc_ook_rssi_regs_i (.clk_sys, .reset, .clk_en, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .rx_mode, .normal_filter, .error_result, .correction_result, .strength_result, .active_filter,
    .slicer_cfg, .error_measure_start, .correction_start, .correction_clear, .strength_start, .irq);
  always #25 clk_sys = ~clk_sys;
  // start pulses are counted so a scenario can check exactly one per trigger
  always @(posedge clk_sys)
  begin
    cyc++;
    n_corr += correction_start;
    n_err += error_measure_start;
    n_str += strength_start;
    n_clr += correction_clear;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
    // one idle edge, so a following call never raises bready in the step that lowered it
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk($sformatf("rd %h", i), s_axi_rdata, {24'h0, d});
    chk("rresp", s_axi_rresp, er);
    // one idle edge, so a following call never raises rready in the step that lowered it
    @(posedge clk_sys);
  endtask
  task automatic feed(input int k, input logic [15:0] v);
    if (k == 0)
      correction_result <= {1'h1, v};
    else if (k == 1)
      error_result <= {1'h1, v};
    else
      strength_result <= {1'h1, v};
    @(posedge clk_sys);
    correction_result <= '0;
    error_result <= '0;
    strength_result <= '0;
    @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rd(IDX_CORR_BW, 8'h8b);
    rd(IDX_PEAK_CFG, 8'h40);
    rd(IDX_AVG_CFG, 8'h80);
    rd(IDX_FIXED, 8'h06);
    rd(IDX_CORR_CTRL, 8'h10);
    rd(IDX_CORR_HI, 8'h00);
    rd(IDX_CORR_LO, 8'h00);
    rd(IDX_STR_CTRL, 8'h02);
    rd(IDX_STR_RESULT, 8'hff);
    rd(6'h0a, 8'h00, RESP_SLVERR);
    wr(6'h0a, 8'hff, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_slicer;
    logic [3:0] st [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
    logic [5:0] cn [4] = '{6'h20, 6'h8, 6'h4, 6'h2};
    logic [4:0] rt;
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_PEAK_CFG, {2'h1, c[2:0], c[2:0]});
      tick;
      chk("type", slicer_cfg.threshold_type, TYPE_PEAK);
      chk("step", slicer_cfg.step_half_db, st[c]);
      rt = c < 4 ? {c[1:0], 3'h0} : {2'h0, 3'(c - 3)};
      chk("rate", {slicer_cfg.decay_chips_log2, slicer_cfg.decays_per_chip_log2}, rt);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_AVG_CFG, {c[1:0], 6'h3f});
      tick;
      chk("corner", slicer_cfg.corner_div_pi, cn[c]);
      rd(IDX_AVG_CFG, {c[1:0], 6'h0});
    end
    wr(IDX_FIXED, 8'h2a);
    wr(IDX_PEAK_CFG, 8'h00);
    tick;
    chk("fixed", slicer_cfg.fixed_level, 8'h2a);
    wr(IDX_PEAK_CFG, 8'h80);
    tick;
    chk("avg", slicer_cfg.threshold_type, TYPE_AVERAGE);
    $display("slicer test done");
  endtask
  task automatic t_meas;
    int n;
    n = n_corr;
    wr(IDX_CORR_CTRL, 8'h01);
    rd(IDX_CORR_CTRL, 8'h00);
    chk("cstart", n_corr - n, 1);
    chk("afilt", active_filter, 8'h8b);
    feed(0, 16'h1234);
    rd(IDX_CORR_CTRL, 8'h10);
    rd(IDX_CORR_HI, 8'h12);
    rd(IDX_CORR_LO, 8'h34);
    chk("afilt", active_filter, 8'h55);
    n = n_err;
    wr(IDX_CORR_CTRL, 8'h20);
    rd(IDX_CORR_CTRL, 8'h10);
    chk("estart", n_err - n, 1);
    feed(1, 16'hfedc);
    feed(1, 16'h0001);
    rd(IDX_CORR_CTRL, 8'h50);
    rd(IDX_ERR_HI, 8'hfe);
    rd(IDX_ERR_LO, 8'hdc);
    wr(IDX_IRQ_STATUS, 8'h07);
    wr(IDX_IRQ_MASK, 8'h04);
    n = n_str;
    wr(IDX_STR_CTRL, 8'h01);
    rd(IDX_STR_CTRL, 8'h00);
    chk("sstart", n_str - n, 1);
    chk("irq", irq, 1'h0);
    feed(2, 16'h005a);
    rd(IDX_STR_CTRL, 8'h02);
    rd(IDX_STR_RESULT, 8'h5a);
    rd(IDX_IRQ_STATUS, 8'h04);
    chk("irq", irq, 1'h1);
    wr(IDX_IRQ_MASK, 8'h00);
    tick;
    chk("irq", irq, 1'h0);
    wr(IDX_IRQ_MASK, 8'h04);
    wr(IDX_IRQ_STATUS, 8'h04);
    tick;
    chk("irq", irq, 1'h0);
    $display("measure test done");
  endtask
  task automatic t_auto;
    int n;
    int m;
    m = n_clr;
    wr(IDX_CORR_CTRL, 8'h02);
    rd(IDX_CORR_LO, 8'h34);
    chk("noclr", n_clr - m, 0);
    n = n_corr;
    m = n_clr;
    rx_mode <= 1'h1;
    wr(IDX_CORR_CTRL, 8'h02);
    rd(IDX_CORR_HI, 8'h00);
    rd(IDX_CORR_CTRL, 8'h50);
    chk("clr", n_clr - m, 1);
    chk("noauto", n_corr - n, 0);
    wr(IDX_CORR_CTRL, 8'h01);
    feed(0, 16'h0042);
    rd(IDX_CORR_LO, 8'h42);
    rx_mode <= 1'h0;
    wr(IDX_CORR_CTRL, 8'h0c);
    n = n_corr;
    rx_mode <= 1'h1;
    tick;
    tick;
    chk("auto", n_corr - n, 1);
    rd(IDX_CORR_LO, 8'h00);
    rd(IDX_CORR_CTRL, 8'h4c);
    $display("auto test done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    t_reset;
    t_slicer;
    t_meas;
    t_auto;
    end_of_test;
  end
endmodule
